// file: rtl/irp_slave.sv
// Purpose: two-wire slave that serves register reads by command
// Assumes: scl and sda already synchronous to clock, no clock stretching
// Notes: sda is open drain, sda_oe_n low pulls the wire to sda_out
`timescale 1ns/100ps
`include "irp_map.svh"

module irp_slave import irp_pkg::*; #(
   parameter int NPORT = 3
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [2:0] addr_strap,
   input wire logic core_wr_en,
   input wire logic [4:0] core_wr_port,
   input wire logic [11:0] core_wr_addr,
   input wire logic [31:0] core_wr_data,
   input wire logic [3:0] core_wr_be,
   output logic [4:0] cmd_port,
   output logic [11:0] cmd_addr,
   output logic [3:0] cmd_be,
   output logic fetch_done
);

   localparam logic [6:0] SLAVE_BASE = `IRP_SLAVE_BASE;

   irp_slave_st_t s_q;
   irp_slave_st_t s_d;

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic addr_match;
   logic [4:0] psel;
   logic [11:0] raddr;
   logic [31:0] rd_data;

   // Bit of the outgoing byte, byte index 0 is register byte 3
   function automatic logic tx_bit(input logic [31:0] d, input logic [1:0] bi, input logic [2:0] ci);
      logic [7:0] b;
      case (bi)
         2'd0: b = d[31:24];
         2'd1: b = d[23:16];
         2'd2: b = d[15:8];
         default: b = d[7:0];
      endcase
      return b[3'd7 - ci];
   endfunction

   assign scl_rise = scl_in & ~s_q.scl_p;
   assign scl_fall = ~scl_in & s_q.scl_p;
   // Start and stop are sda moves while scl stays high
   assign start_seen = scl_in & s_q.scl_p & s_q.sda_p & ~sda_in;
   assign stop_seen = scl_in & s_q.scl_p & ~s_q.sda_p & sda_in;

   // straps replace the low address bits
   assign addr_match = s_q.strap_ok && (s_q.sh[7:1] == {SLAVE_BASE[6:3], s_q.strap});

   assign psel = {s_q.c1[`IRP_PSEL_HI_MSB:0], s_q.c2[`IRP_PSEL0_BIT]};
   assign raddr = {s_q.c2[`IRP_AHI_MSB:0], s_q.c3, 2'b00};

   irp_regfile #(
      .NPORT(NPORT)
   ) u_regs (
      .clock(clock),
      .rst(rst),
      .rd_port(psel),
      .rd_addr(raddr),
      .rd_data(rd_data),
      .wr_en(core_wr_en),
      .wr_port(core_wr_port),
      .wr_addr(core_wr_addr),
      .wr_data(core_wr_data),
      .wr_be(core_wr_be)
   );

   always_comb begin
      s_d = s_q;
      s_d.scl_p = scl_in;
      s_d.sda_p = sda_in;
      s_d.fetch = 1'b0;
      s_d.fetched = 1'b0;

      // Straps are caught once, the cycle after reset is released
      if (!s_q.strap_ok) begin
         s_d.strap = addr_strap;
         s_d.strap_ok = 1'b1;
      end

      if (s_q.fetch) begin
         // only the read opcode loads the buffer
         // reserved bits of byte 0 not looked at
         if (s_q.c0[`IRP_OP_MSB:0] == `IRP_OP_READ) begin
            s_d.rbuf = rd_data;
            s_d.fetched = 1'b1;
         end
      end

      if (start_seen) begin
         s_d.st = st_rx;
         s_d.cnt = 3'd0;
         s_d.done = 1'b0;
         s_d.addr_ph = 1'b1;
         s_d.oe_n = 1'b1;
      end else if (stop_seen) begin
         s_d.st = st_idle;
         s_d.oe_n = 1'b1;
      end else begin
         case (s_q.st)
            st_idle: begin
               s_d.oe_n = 1'b1;
            end
            st_rx: begin
               if (scl_rise) begin
                  s_d.sh = {s_q.sh[6:0], sda_in};
                  s_d.cnt = s_q.cnt + 3'd1;
                  s_d.done = (s_q.cnt == 3'd7);
               end else if (scl_fall && s_q.done) begin
                  s_d.done = 1'b0;
                  s_d.cnt = 3'd0;
                  if (s_q.addr_ph) begin
                     s_d.addr_ph = 1'b0;
                     if (addr_match) begin
                        s_d.st = st_rx_ack;
                        s_d.oe_n = 1'b0;
                        s_d.to_tx = s_q.sh[0];
                        s_d.cidx = 3'd0;
                        s_d.bidx = 2'd0;
                     end else begin
                        s_d.st = st_skip;
                     end
                  end else if (s_q.cidx < 3'd4) begin
                     s_d.st = st_rx_ack;
                     s_d.oe_n = 1'b0;
                     s_d.to_tx = 1'b0;
                     s_d.cidx = s_q.cidx + 3'd1;
                     case (s_q.cidx[1:0])
                        2'd0: s_d.c0 = s_q.sh;
                        2'd1: s_d.c1 = s_q.sh;
                        2'd2: s_d.c2 = s_q.sh;
                        default: begin
                           s_d.c3 = s_q.sh;
                           s_d.fetch = 1'b1;
                        end
                     endcase
                  end else begin
                     // Extra bytes past the command are not acked
                     s_d.st = st_skip;
                  end
               end
            end
            st_rx_ack: begin
               if (scl_fall) begin
                  s_d.cnt = 3'd0;
                  if (s_q.to_tx) begin
                     s_d.st = st_tx;
                     s_d.oe_n = tx_bit(s_q.rbuf, s_q.bidx, 3'd0);
                  end else begin
                     s_d.st = st_rx;
                     s_d.oe_n = 1'b1;
                  end
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  if (s_q.cnt == 3'd7) begin
                     s_d.st = st_tx_ack;
                     s_d.cnt = 3'd0;
                     s_d.done = 1'b0;
                     s_d.oe_n = 1'b1;
                  end else begin
                     s_d.cnt = s_q.cnt + 3'd1;
                     s_d.oe_n = tx_bit(s_q.rbuf, s_q.bidx, s_q.cnt + 3'd1);
                  end
               end
            end
            st_tx_ack: begin
               if (scl_rise) begin
                  // master nack ends the data phase
                  if (sda_in) begin
                     s_d.st = st_skip;
                  end else begin
                     s_d.done = 1'b1;
                  end
               end else if (scl_fall && s_q.done) begin
                  s_d.done = 1'b0;
                  s_d.st = st_tx;
                  // byte 3 first, byte 0 last
                  // index wraps back to byte 3
                  s_d.bidx = s_q.bidx + 2'd1;
                  s_d.oe_n = tx_bit(s_q.rbuf, s_q.bidx + 2'd1, 3'd0);
               end
            end
            st_skip: begin
               s_d.oe_n = 1'b1;
            end
            default: begin
               s_d.st = st_idle;
               s_d.oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '{st: st_idle, scl_p: 1'b1, sda_p: 1'b1, cnt: 3'd0, done: 1'b0, sh: 8'h00,
                  addr_ph: 1'b0, to_tx: 1'b0, cidx: 3'd0, c0: 8'h00, c1: 8'h00, c2: 8'h00,
                  c3: 8'h00, fetch: 1'b0, fetched: 1'b0, rbuf: 32'h0000_0000, bidx: 2'd0,
                  oe_n: 1'b1, strap: 3'h0, strap_ok: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Open drain: only a low is ever driven
   assign sda_out = 1'b0;
   assign sda_oe_n = s_q.oe_n;
   assign cmd_port = psel;
   assign cmd_addr = raddr;
   // byte enable field of command byte 2
   assign cmd_be = s_q.c2[`IRP_BE_MSB:`IRP_BE_LSB];
   assign fetch_done = s_q.fetched;

endmodule

// file: rtl/irp_map.svh
// Purpose: constants for the two-wire register read port
// Assumes: 32-bit registers, dword addressed, 12-bit byte address
// Notes: included by both modules
`ifndef IRP_MAP_SVH
`define IRP_MAP_SVH

`define IRP_SLAVE_BASE 7'h68
`define IRP_OP_READ 3'h4
`define IRP_OP_MSB 2
`define IRP_PSEL_HI_MSB 3
`define IRP_PSEL0_BIT 7
`define IRP_BE_MSB 5
`define IRP_BE_LSB 2
`define IRP_AHI_MSB 1
`define IRP_SSID_OFFSET 12'h0f8
`define IRP_SSID_RESET 32'h0000_0000

`endif

// file: rtl/irp_pkg.sv
// Purpose: types shared by the register read port
// Assumes: nothing beyond the map header
// Notes: slave state is one packed struct
package irp_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_rx,
      st_rx_ack,
      st_tx,
      st_tx_ack,
      st_skip
   } irp_state_t;

   typedef struct packed {
      irp_state_t st;
      logic scl_p;
      logic sda_p;
      logic [2:0] cnt;
      logic done;
      logic [7:0] sh;
      logic addr_ph;
      logic to_tx;
      logic [2:0] cidx;
      logic [7:0] c0;
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] c3;
      logic fetch;
      logic fetched;
      logic [31:0] rbuf;
      logic [1:0] bidx;
      logic oe_n;
      logic [2:0] strap;
      logic strap_ok;
   } irp_slave_st_t;

endpackage

// file: rtl/irp_regfile.sv
// Purpose: per-port register storage behind the read port
// Assumes: one subsystem identification register per port
// Notes: read is combinational, write comes from the core side
`timescale 1ns/100ps
`include "irp_map.svh"

module irp_regfile import irp_pkg::*; #(
   parameter int NPORT = 3
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [4:0] rd_port,
   input wire logic [11:0] rd_addr,
   output logic [31:0] rd_data,
   input wire logic wr_en,
   input wire logic [4:0] wr_port,
   input wire logic [11:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] wr_be
);

   typedef struct packed {
      logic [NPORT-1:0][31:0] ssid;
   } irp_rf_st_t;

   irp_rf_st_t s_q;
   irp_rf_st_t s_d;

   // Same decode serves both read and write so they never disagree
   function automatic logic hit(input logic [4:0] p, input logic [11:0] a, input int i);
      logic [31:0] iw;
      iw = i;
      return (p == iw[4:0]) && (a == `IRP_SSID_OFFSET);
   endfunction

   always_comb begin
      s_d = s_q;
      rd_data = 32'h0000_0000;
      for (int i = 0; i < NPORT; i++) begin
         if (hit(rd_port, rd_addr, i)) begin
            rd_data = s_q.ssid[i];
         end
         if (wr_en && hit(wr_port, wr_addr, i)) begin
            for (int b = 0; b < 4; b++) begin
               if (wr_be[b]) begin
                  s_d.ssid[i][8*b +: 8] = wr_data[8*b +: 8];
               end
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '{ssid: {NPORT{`IRP_SSID_RESET}}};
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// file: verification/irp_master.sv
// Purpose: two-wire bus master model for the read port
// Assumes: pull-up on sda, scl driven only by this model
// Notes: steps on falling clock edges, scl stands still between frames
`timescale 1ns/100ps
module irp_master (
   input wire logic clock,
   input wire logic sda_oe_n,
   input wire logic sda_out,
   output logic scl,
   output logic sda
);
   logic sda_m = 1'h1;
   initial scl = 1'h1;
   // Pull-up wins when nobody pulls low
   assign sda = sda_m & (sda_oe_n | sda_out);
   task automatic w(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Sda moves only with scl low, three clocks setup, two hold
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      w(3);
      scl = 1'h1;
      w(2);
      r = sda;
      w(2);
      scl = 1'h0;
      w(2);
   endtask
   task automatic start();
      sda_m = 1'h1;
      w(3);
      scl = 1'h1;
      w(3);
      sda_m = 1'h0;
      w(3);
      scl = 1'h0;
      w(2);
   endtask
   task automatic stop();
      sda_m = 1'h0;
      w(3);
      scl = 1'h1;
      w(3);
      sda_m = 1'h1;
      w(3);
   endtask
   task automatic tx(input logic [7:0] b, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'h1, r);
      ak = !r;
   endtask
   task automatic rx(input logic ak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
      bit_io(!ak, r);
   endtask
endmodule

// file: verification/irp_slave_checker.sv
// Purpose: port-level checks of the register read port
// Assumes: one clock domain, reset active high
// Notes: bound to every irp_slave instance
`timescale 1ns/100ps
module irp_slave_checker #(
   parameter int NPORT = 3
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic [4:0] cmd_port,
   input wire logic [11:0] cmd_addr,
   input wire logic [3:0] cmd_be,
   input wire logic fetch_done
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_drive_hold;
      !sda_oe_n [*5];
   endsequence
   sequence s_cmd_move;
      $changed(cmd_port) || $changed(cmd_addr) || $changed(cmd_be);
   endsequence
   // Scl was high two samples back and has been low since
   sequence s_scl_fell;
      !scl_in && !$past(scl_in) && $past(scl_in, 2);
   endsequence
   property p_fetch_pulse;
      fetch_done |=> !fetch_done;
   endproperty
   a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch_done too long");
   property p_fetch_cmd;
      fetch_done |-> $stable(cmd_port) && $stable(cmd_addr) && $stable(cmd_be);
   endproperty
   a_fetch_cmd: assert property (p_fetch_cmd) else $error("command moved at fetch");
   property p_fetch_low;
      fetch_done |-> !scl_in;
   endproperty
   a_fetch_low: assert property (p_fetch_low) else $error("fetch with scl high");
   property p_cmd_low;
      s_cmd_move |-> !scl_in;
   endproperty
   a_cmd_low: assert property (p_cmd_low) else $error("command latched with scl high");
   property p_addr_align;
      cmd_addr[1:0] == 2'h0;
   endproperty
   a_addr_align: assert property (p_addr_align) else $error("address low bits set");
   property p_oe_low;
      $changed(sda_oe_n) |-> !scl_in;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("sda moved with scl high");
   property p_oe_after_fall;
      $changed(sda_oe_n) |-> s_scl_fell;
   endproperty
   a_oe_after_fall: assert property (p_oe_after_fall) else $error("sda moved away from scl fall");
   property p_ack_hold;
      $fell(sda_oe_n) |-> s_drive_hold;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("sda drive too short");
   property p_open_drain;
      sda_out == 1'h0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda_out not low");
endmodule

// file: verification/i2c_register_read_port_bench.sv
// Purpose: self-checking bench of the register read port
// Assumes: only offset F8h is backed, per mapped port
// Notes: random commands with fixed seed, plus the all-zero example read
`timescale 1ns/100ps
module i2c_register_read_port_bench;
   localparam int NPORT = 3;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic [2:0] addr_strap = 3'h0;
   logic core_wr_en = 1'h0;
   logic [4:0] core_wr_port = 5'h00;
   logic [11:0] core_wr_addr = 12'h0f8;
   logic [31:0] core_wr_data = 32'h0;
   logic [3:0] core_wr_be = 4'h0;
   logic scl, sda, sda_out, sda_oe_n, fetch_done;
   logic [4:0] cmd_port;
   logic [11:0] cmd_addr;
   logic [3:0] cmd_be;
   logic [31:0] mem [NPORT];
   logic [31:0] exp_buf;
   logic [6:0] sa = 7'h68;
   int err_total = 0;
   int n_compared = 0;
   int seed = 1090;
   int n_fetch = 0;
   always #50 clock = ~clock;
   // Counted on the falling edge, away from the edge that launches the pulse
   always @(negedge clock) if (fetch_done === 1'h1) n_fetch++;
   irp_slave #(.NPORT(NPORT)) u_irp_slave (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap), .core_wr_en(core_wr_en),
      .core_wr_port(core_wr_port), .core_wr_addr(core_wr_addr), .core_wr_data(core_wr_data),
      .core_wr_be(core_wr_be), .cmd_port(cmd_port), .cmd_addr(cmd_addr), .cmd_be(cmd_be),
      .fetch_done(fetch_done));
   irp_master u_irp_master (.clock(clock), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl(scl), .sda(sda));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic reset_with(input logic [2:0] s);
      @(negedge clock);
      rst = 1'h1;
      addr_strap = s;
      repeat (8) @(negedge clock);
      rst = 1'h0;
      repeat (3) @(negedge clock);
      foreach (mem[i]) mem[i] = 32'h0;
      exp_buf = 32'h0;
   endtask
   task automatic core_wr(input logic [4:0] p, input logic [31:0] d, input logic [3:0] be);
      @(negedge clock);
      core_wr_en = 1'h1;
      core_wr_port = p;
      core_wr_data = d;
      core_wr_be = be;
      @(negedge clock);
      core_wr_en = 1'h0;
      for (int b = 0; b < 4; b++) if (p < NPORT && be[b]) mem[p][8*b+:8] = d[8*b+:8];
   endtask
   function automatic logic [31:0] exp_reg(input logic [4:0] p, input logic [11:0] a);
      return (p < NPORT && a == 12'h0f8) ? mem[p] : 32'h0;
   endfunction
   task automatic cmd(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
      logic ak;
      logic [7:0] c [4];
      int n0;
      c = '{c0, c1, c2, c3};
      n0 = n_fetch;
      u_irp_master.start();
      u_irp_master.tx({sa, 1'h0}, ak);
      chk("ack select", ak, 1'h1);
      foreach (c[i]) begin
         u_irp_master.tx(c[i], ak);
         chk("ack command", ak, 1'h1);
      end
      repeat (3) @(negedge clock);
      chk("fetch_done", n_fetch - n0, c0[2:0] == 3'h4);
      if (c0[2:0] == 3'h4) begin
         exp_buf = exp_reg({c1[3:0], c2[7]}, {c2[1:0], c3, 2'h0});
         chk("cmd_port", cmd_port, {c1[3:0], c2[7]});
         chk("cmd_addr", cmd_addr, {c2[1:0], c3, 2'h0});
         chk("cmd_be", cmd_be, c2[5:2]);
      end
   endtask
   task automatic rd(input logic rs, input int n);
      logic ak;
      logic [7:0] d;
      if (!rs) u_irp_master.stop();
      u_irp_master.start();
      u_irp_master.tx({sa, 1'h1}, ak);
      chk("ack data addr", ak, 1'h1);
      for (int i = 0; i < n; i++) begin
         u_irp_master.rx(i < n - 1, d);
         chk("read byte", d, exp_buf[31-8*(i%4)-:8]);
      end
      u_irp_master.stop();
   endtask
   initial begin
      logic [31:0] r, r2;
      logic [4:0] p;
      logic ak;
      reset_with(3'h0);
      cmd(8'h04, 8'h00, 8'h3c, 8'h3e);
      rd(1'h0, 4);
      for (int k = 0; k < 10; k++) begin
         r = $random(seed);
         r2 = $random(seed);
         core_wr({3'h0, r2[9:8]}, $random(seed), r2[15:12]);
         p = {3'h0, r[9:8]};
         // Stale buffer must survive a later core write
         cmd({r[15:11], r[10] ? 3'h4 : r[2:0]}, {r[19:16], p[4:1]},
            {p[0], r[20], r[25:22], r[28] ? 2'h0 : r[27:26]}, r[28] ? 8'h3e : r2[7:0]);
         core_wr(p, r2, r[31:28]);
         rd(r[5], 6);
      end
      reset_with(3'h5);
      sa = 7'h6d;
      u_irp_master.start();
      u_irp_master.tx(8'hd0, ak);
      chk("ack default addr", ak, 1'h0);
      u_irp_master.stop();
      cmd(8'h04, 8'h02, 8'hbc, 8'h3e);
      u_irp_master.tx(8'h55, ak);
      chk("ack extra byte", ak, 1'h0);
      rd(1'h1, 4);
      complete_run();
   end
   initial begin
      #4_000_000;
      err_total++;
      complete_run();
   end
endmodule
bind irp_slave irp_slave_checker #(.NPORT(NPORT)) u_irp_slave_checker (.clock(clock), .rst(rst),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cmd_port(cmd_port), .cmd_addr(cmd_addr),
   .cmd_be(cmd_be), .fetch_done(fetch_done));
